// ---- sim/host_bus_model.sv ----
// host side of the shared data and parity lines, parity above data
`timescale 1ns/100ps
module host_bus_model (
  // clock and host drive
  input  wire logic        core_clk,
  input  wire logic        host_en,
  input  wire logic [35:0] hdata,
  // device drive
  input  wire logic [35:0] dev_val,
  input  wire logic [35:0] dev_oe,
  // resolved lines
  output logic      [35:0] line
);
  logic [35:0] last_q;
  // released lines show the inverse of their last level, so a stale value never passes
  assign line = (dev_oe & dev_val) | (~dev_oe & (host_en ? hdata : ~last_q));
  always_ff @(posedge core_clk) begin
    last_q <= line;
  end
endmodule

// ---- sim/sram_port_monitor.sv ----
// pin-level checker for the flow-through burst sram port
`timescale 1ns/100ps
module sram_port_monitor
  import burst_sram_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_WIDTH_DEF,
  parameter int LANES      = LANES_DEF
) (
  // clock, reset and controls
  input wire logic                        core_clk, resetn, clock_qualify_n, chip_select_1_n,
  input wire logic                        chip_select_2, chip_select_3_n, advance_or_load,
  input wire logic                        write_strobe_n, output_drive_enable_n, burst_order,
  input wire logic                        sleep_request, asleep,
  input wire logic [LANES-1:0]            byte_lane_select_n,
  input wire logic [ADDR_WIDTH-1:0]       address,
  // shared lines
  input wire logic [LANES*BYTE_WIDTH-1:0] data_in, data_out, data_oe,
  input wire logic [LANES-1:0]            shared_parity_lines_in, shared_parity_lines_out,
  input wire logic [LANES-1:0]            shared_parity_lines_oe
);
  logic [1:0] up_q;
  logic [1:0] up_d;
  logic       sel;
  logic       go;
  logic       quiet;
  // the port drops requests for two edges after release, so wait out three
  always_comb begin
    up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      up_q <= 2'h0;
    end else begin
      up_q <= up_d;
    end
  end
  // decode of a qualified load and of a floating bus
  assign sel   = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign go    = !clock_qualify_n && up_q == 2'h3 && !sleep_request && !asleep;
  assign quiet = data_oe == '0 && shared_parity_lines_oe == '0;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence rd_load; go && sel && write_strobe_n && !advance_or_load && !output_drive_enable_n; endsequence
  sequence wr_load; go && sel && !write_strobe_n && !advance_or_load; endsequence
  sequence ds_load; go && !sel && !advance_or_load; endsequence
  sequence run2; (!clock_qualify_n && !sleep_request)[*2]; endsequence
  chk_read_drive: assert property (rd_load ##1 (run2 and (!output_drive_enable_n)[*2]) |=> &data_oe)
    else $error("read beat not driven");
  chk_write_float: assert property (wr_load ##1 run2 |=> quiet)
    else $error("driven during write data cycle");
  chk_desel_float: assert property (ds_load ##1 run2 |=> quiet)
    else $error("driven after deselect");
  chk_oe_float: assert property (output_drive_enable_n[*3] |=> quiet)
    else $error("driven with enable high");
  chk_lanes_whole: assert property (quiet || (&data_oe && &shared_parity_lines_oe))
    else $error("lanes driven unevenly");
  chk_freeze_hold: assert property ((clock_qualify_n && up_q == 2'h3)[*4] |=> $stable(data_out))
    else $error("output moved while frozen");
  chk_sleep_enter: assert property ((sleep_request && up_q == 2'h3)[*4] |-> asleep)
    else $error("sleep not entered");
  chk_sleep_exit: assert property ((!sleep_request)[*6] |-> !asleep)
    else $error("sleep not left");
  chk_sleep_float: assert property (asleep[*3] |-> quiet)
    else $error("driven while asleep");
  chk_reset_quiet: assert property (disable iff (1'b0) !resetn |-> quiet && !asleep)
    else $error("not quiet in reset");
endmodule

bind flow_through_burst_sram_port sram_port_monitor #(.ADDR_WIDTH(ADDR_WIDTH), .LANES(LANES)) mon_u (
  .core_clk, .resetn, .clock_qualify_n, .chip_select_1_n, .chip_select_2, .chip_select_3_n,
  .advance_or_load, .write_strobe_n, .output_drive_enable_n, .burst_order, .sleep_request,
  .asleep, .byte_lane_select_n, .address, .data_in, .data_out, .data_oe, .shared_parity_lines_in,
  .shared_parity_lines_out, .shared_parity_lines_oe
);

// ---- sim/testbench.sv ----
// self-checking bench for the flow-through burst sram port
`timescale 1ns/100ps
module testbench;
  logic        core_clk, resetn, qn, adv, wen, oen, order, slp, host_en, asleep;
  logic [2:0]  cs, dsel;
  logic [3:0]  ln, pout, poe;
  logic [9:0]  addr;
  logic [31:0] dout, doe;
  logic [35:0] hdata, e0, e1;
  logic [35:0] mem_e [1024];
  logic [1:0]  v0, v1;
  wire  [35:0] line;
  int          miscompares = 0;
  int          n_checks = 0;

  // design and host side of the bus
  flow_through_burst_sram_port dut_u (
    .core_clk, .resetn, .clock_qualify_n(qn), .chip_select_1_n(cs[2]), .chip_select_2(cs[1]),
    .chip_select_3_n(cs[0]), .advance_or_load(adv), .write_strobe_n(wen), .byte_lane_select_n(ln),
    .address(addr), .output_drive_enable_n(oen), .burst_order(order), .sleep_request(slp),
    .data_in(line[31:0]), .data_out(dout), .data_oe(doe), .shared_parity_lines_in(line[35:32]),
    .shared_parity_lines_out(pout), .shared_parity_lines_oe(poe), .asleep
  );
  host_bus_model host_u (.core_clk, .host_en, .hdata, .dev_val({pout, dout}), .dev_oe({poe, doe}), .line);

  task automatic check(input string s, input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  function automatic logic [9:0] bad(input logic [9:0] a, input logic [1:0] i);
    return {a[9:2], order ? a[1:0] ^ i : a[1:0] + i};
  endfunction

  // one bus cycle; outputs of the cycle two before are judged once this edge has landed
  task automatic cmd(input int k, input logic [9:0] a, input logic [3:0] m, input logic [1:0] dv,
                     input logic [35:0] ev);
    adv = k == 3;
    wen = k < 2;
    cs = k == 0 ? dsel : k == 3 ? 3'h5 : 3'h2;
    addr = a;
    ln = m;
    @(posedge core_clk);
    #1;
    host_en = 0;
    if (v1 != 2'h2) check("drive", {poe, doe}, {36{v1[0]}});
    if (v1 == 2'h1) check("read data", {pout, dout}, e1);
    {v1, e1, v0, e0} = {v0, e0, dv, ev};
  endtask

  task automatic idle(input int n);
    repeat (n) cmd(0, 10'h000, 4'hf, 2'h0, '0);
  endtask

  // advance beats put the inverse address on the pins, which must be ignored
  task automatic wr(input logic [9:0] a, input logic [35:0] d, input logic [3:0] m, input int k);
    cmd(k, k == 3 ? ~a : a, m, 2'h0, '0);
    hdata = d;
    host_en = 1;
    for (int i = 0; i < 4; i++) begin
      if (!m[i]) begin
        mem_e[a][8*i +: 8] = d[8*i +: 8];
        mem_e[a][32+i] = d[32+i];
      end
    end
  endtask

  task automatic rd(input int k, input logic [9:0] a);
    cmd(k, k == 3 ? ~a : a, 4'h0, {1'b0, !oen}, mem_e[a]);
  endtask

  task automatic t_reset;
    check("reset drive", {poe, doe}, 36'h0);
    check("reset sleep", {35'h0, asleep}, 36'h0);
    $display("t_reset done");
  endtask

  task automatic t_rw;
    wr(10'h040, 36'h1_2345_6789, 4'h0, 2);
    rd(1, 10'h040);
    wr(10'h041, 36'hE_DCBA_9876, 4'h0, 2);
    rd(1, 10'h041);
    rd(1, 10'h040);
    idle(2);
    $display("t_rw done");
  endtask

  task automatic t_lanes;
    wr(10'h042, 36'hF_FFFF_FFFF, 4'h0, 2);
    wr(10'h042, 36'h0, 4'ha, 2);
    wr(10'h042, 36'h0, 4'hf, 2);
    rd(1, 10'h042);
    idle(2);
    $display("t_lanes done");
  endtask

  task automatic t_burst;
    for (int o = 0; o < 2; o++) begin
      order = o;
      for (int i = 0; i < 4; i++) wr(bad(10'h0A5, 2'(i)), {4'h9, 24'hA5_0000, 4'(o), 4'(i)}, 4'h0, i ? 3 : 2);
      for (int i = 0; i < 4; i++) rd(i ? 3 : 1, bad(10'h0A5, 2'(i)));
      idle(2);
    end
    $display("t_burst done");
  endtask

  // frozen edges carry an advance that must not step the counter
  task automatic t_freeze;
    order = 0;
    cmd(1, 10'h0A4, 4'h0, 2'h2, '0);
    qn = 1;
    repeat (4) cmd(3, 10'h000, 4'h0, 2'h2, '0);
    qn = 0;
    rd(3, 10'h0A5);
    rd(3, 10'h0A6);
    idle(2);
    $display("t_freeze done");
  endtask

  task automatic t_oe;
    oen = 1;
    rd(1, 10'h040);
    idle(3);
    oen = 0;
    for (int p = 0; p < 3; p++) begin
      dsel = p == 0 ? 3'h6 : p == 1 ? 3'h0 : 3'h3;
      rd(1, 10'h041);
      idle(1);
    end
    idle(2);
    dsel = 3'h6;
    $display("t_oe done");
  endtask

  task automatic t_sleep;
    idle(2);
    slp = 1;
    idle(5);
    check("asleep", {35'h0, asleep}, 36'h1);
    slp = 0;
    idle(6);
    check("awake", {35'h0, asleep}, 36'h0);
    rd(1, 10'h042);
    idle(2);
    $display("t_sleep done");
  endtask

  // clock and watchdog
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #5000;
    miscompares++;
    wrap_up();
  end

  // reset, then the scenarios in turn
  initial begin
    {qn, adv, oen, order, slp, host_en, resetn} = '0;
    {wen, cs, dsel, ln} = {1'b1, 3'h6, 3'h6, 4'hf};
    {addr, hdata, e0, e1} = '0;
    {v0, v1} = 4'ha;
    repeat (2) @(posedge core_clk);
    #1;
    resetn = 1;
    idle(3);
    t_reset();
    t_rw();
    t_lanes();
    t_burst();
    t_freeze();
    t_oe();
    t_sleep();
    wrap_up();
  end
endmodule

// ---- src/burst_sram_pkg.sv ----
// constants shared by the flow-through burst sram port
package burst_sram_pkg;
  localparam int ADDR_WIDTH_DEF  = 10;
  localparam int LANES_DEF       = 4;
  localparam int BYTE_WIDTH      = 8;
  localparam int LANE_WIDTH      = 9;   // byte plus its parity bit
  localparam int BURST_LEN       = 4;
  localparam int BURST_BITS      = 2;
  localparam int SLEEP_CYCLES    = 2;   // entry and exit each take two cycles
  localparam logic [1:0] SLEEP_CNT_RESET = 2'h0;
  localparam logic [1:0] STEP_ONE        = 2'h1;
  localparam logic       ORDER_LINEAR    = 1'b0;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10
  } op_type;

  typedef enum logic [1:0] {
    PWR_AWAKE    = 2'b00,
    PWR_ENTERING = 2'b01,
    PWR_ASLEEP   = 2'b10,
    PWR_LEAVING  = 2'b11
  } pwr_type;
endpackage

// ---- src/flow_through_burst_sram_port.sv ----
// flow-through burst sram port: control, burst counter, sleep and data drivers
//
// What this block does
// - register every synchronous input on rising edge
// - qualifier high freezes operation, burst and write state; sleep sequencer, input capture and output enable keep running
// - read starts: selects active, strobe high, load
// - read data appears two edges after capturing edge
// - read data driven only if enable was low at the edge that drives it
// - deselect at load floats data lines
// - new operation accepted right after read start
// - burst counter gives four accesses per address
// - order setting picks linear or interleaved
// - advance high steps counter, ignores selects, strobe
// - direction latched at load, kept whole burst
// - write starts: selects active, strobe low
// - write data latched next edge; overlap allowed
// - only selected lanes and parity written
// - data drivers float in every write cycle
// - sleep keeps data; two cycles in, out
// - access pending at sleep may be lost
// - interleaved: low bits xor step index
// - linear: low bits plus step modulo four
// - write with no lanes writes nothing
// - powers up deselected with floating data
`timescale 1ns/100ps
module flow_through_burst_sram_port
  import burst_sram_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_WIDTH_DEF,
  parameter int LANES      = LANES_DEF
) (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  // control inputs from the host
  input  wire logic                          clock_qualify_n,
  input  wire logic                          chip_select_1_n,
  input  wire logic                          chip_select_2,
  input  wire logic                          chip_select_3_n,
  input  wire logic                          advance_or_load,
  input  wire logic                          write_strobe_n,
  input  wire logic [LANES-1:0]              byte_lane_select_n,
  input  wire logic [ADDR_WIDTH-1:0]         address,
  input  wire logic                          output_drive_enable_n,
  input  wire logic                          burst_order,
  input  wire logic                          sleep_request,
  // shared data lines, split into in, out and enable
  input  wire logic [LANES*BYTE_WIDTH-1:0]   data_in,
  output logic      [LANES*BYTE_WIDTH-1:0]   data_out,
  output logic      [LANES*BYTE_WIDTH-1:0]   data_oe,
  input  wire logic [LANES-1:0]              shared_parity_lines_in,
  output logic      [LANES-1:0]              shared_parity_lines_out,
  output logic      [LANES-1:0]              shared_parity_lines_oe,
  // sleep status
  output logic                               asleep
);
  // elaboration-time refusal of sizes the burst counter or lanes cannot serve
  if (ADDR_WIDTH < BURST_BITS || LANES < 1) begin : g_bad_params
    $error("flow_through_burst_sram_port: address must hold burst bits and lanes must be nonzero");
  end

  localparam int DW = LANES * BYTE_WIDTH;

  // burst address: step only the two low bits, keep the rest
  function automatic logic [ADDR_WIDTH-1:0] next_addr(input logic [ADDR_WIDTH-1:0] base,
                                                      input logic [1:0]            step,
                                                      input logic                  order);
    logic [1:0] low;
    low = (order == ORDER_LINEAR) ? base[1:0] + step
                                  : base[1:0] ^ step;
    next_addr = {base[ADDR_WIDTH-1:BURST_BITS], low};
  endfunction

  // pack data and parity into lanes of nine bits
  function automatic logic [LANES*LANE_WIDTH-1:0] pack(input logic [DW-1:0]    d,
                                                       input logic [LANES-1:0] p);
    for (int i = 0; i < LANES; i++) begin
      pack[i*LANE_WIDTH +: LANE_WIDTH] = {p[i], d[i*BYTE_WIDTH +: BYTE_WIDTH]};
    end
  endfunction

  // reset release through two flip-flops
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire logic rst_n = rst_sync_q;

  // input capture registers
  logic                  qual_n_q, cs1_n_q, cs2_q, cs3_n_q, adv_q, we_n_q, oe_n_q, order_q, zz_q;
  logic [LANES-1:0]      bw_n_q;
  logic [ADDR_WIDTH-1:0] addr_in_q;
  logic [DW-1:0]         din_q;
  logic [LANES-1:0]      pin_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      qual_n_q  <= 1'b1;
      cs1_n_q   <= 1'b1;
      cs2_q     <= 1'b0;
      cs3_n_q   <= 1'b1;
      adv_q     <= 1'b0;
      we_n_q    <= 1'b1;
      oe_n_q    <= 1'b1;
      order_q   <= 1'b0;
      zz_q      <= 1'b0;
      bw_n_q    <= '1;
      addr_in_q <= '0;
      din_q     <= '0;
      pin_q     <= '0;
    end else begin
      qual_n_q  <= clock_qualify_n;
      cs1_n_q   <= chip_select_1_n;
      cs2_q     <= chip_select_2;
      cs3_n_q   <= chip_select_3_n;
      adv_q     <= advance_or_load;
      we_n_q    <= write_strobe_n;
      oe_n_q    <= output_drive_enable_n;
      order_q   <= burst_order;
      zz_q      <= sleep_request;
      bw_n_q    <= byte_lane_select_n;
      addr_in_q <= address;
      din_q     <= data_in;
      pin_q     <= shared_parity_lines_in;
    end
  end

  // operation state
  op_type                op_q, op_d;
  logic [ADDR_WIDTH-1:0] base_q, base_d;
  logic [1:0]            step_q, step_d;
  logic [ADDR_WIDTH-1:0] cur_addr;
  logic                  wr_pend_q, wr_pend_d;
  logic [ADDR_WIDTH-1:0] wr_addr_q, wr_addr_d;
  logic [LANES-1:0]      wr_lane_q, wr_lane_d;
  logic                  rd_valid_q, rd_valid_d;
  logic                  selected;
  logic                  awake;

  // sleep sequencer
  pwr_type   pwr_q, pwr_d;
  logic [1:0] slp_cnt_q, slp_cnt_d;
  logic       asleep_d;

  assign cur_addr = next_addr(base_q, step_q, order_q);
  assign selected = !cs1_n_q && cs2_q && !cs3_n_q;
  assign awake    = (pwr_q == PWR_AWAKE);

  // next operation, decided from the captured inputs
  always_comb begin
    op_d       = op_q;
    base_d     = base_q;
    step_d     = step_q;
    wr_pend_d  = 1'b0;
    wr_addr_d  = wr_addr_q;
    wr_lane_d  = wr_lane_q;
    rd_valid_d = 1'b0;
    if (!awake) begin
      op_d = OP_IDLE;
    end else if (qual_n_q) begin
      wr_pend_d  = wr_pend_q;
      rd_valid_d = rd_valid_q;
    end else if (!adv_q) begin
      if (!selected) begin
        op_d = OP_IDLE;
      end else begin
        base_d = addr_in_q;
        step_d = 2'h0;
        op_d   = we_n_q ? OP_READ : OP_WRITE;
      end
    end else if (op_q != OP_IDLE) begin
      step_d = step_q + STEP_ONE;
    end
    // the data phase of a cycle follows its command by one edge
    if (awake && !qual_n_q) begin
      if (op_d == OP_WRITE) begin
        wr_pend_d = 1'b1;
        wr_addr_d = next_addr(base_d, step_d, order_q);
        wr_lane_d = ~bw_n_q;
      end
      rd_valid_d = (op_d == OP_READ);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q       <= OP_IDLE;
      base_q     <= '0;
      step_q     <= 2'h0;
      wr_pend_q  <= 1'b0;
      wr_addr_q  <= '0;
      wr_lane_q  <= '0;
      rd_valid_q <= 1'b0;
    end else begin
      op_q       <= op_d;
      base_q     <= base_d;
      step_q     <= step_d;
      wr_pend_q  <= wr_pend_d;
      wr_addr_q  <= wr_addr_d;
      wr_lane_q  <= wr_lane_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // write commits when the data edge is a qualified one
  logic commit;
  assign commit = wr_pend_q && !qual_n_q && awake;

  // read address of this edge, shared by the array and the bypass compare
  logic [ADDR_WIDTH-1:0] rd_addr_now;
  assign rd_addr_now = next_addr(base_d, step_d, order_q);

  logic [LANES*LANE_WIDTH-1:0] rd_word;
  sram_array #(
    .ADDR_WIDTH (ADDR_WIDTH),
    .LANES      (LANES)
  ) u_array (
    .core_clk  (core_clk),
    .wr_en     (commit),
    .wr_lane   (wr_lane_q),
    .wr_addr   (wr_addr_q),
    .wr_data   (pack(din_q, pin_q)),
    .rd_addr   (rd_addr_now),
    .rd_data_q (rd_word)
  );

  // a read landing on the word committed at the same edge would see the old
  // word in the array, so the committed lanes travel alongside and are merged
  logic                        fwd_hit_q, fwd_hit_d;
  logic [LANES-1:0]            fwd_lane_q, fwd_lane_d;
  logic [LANES*LANE_WIDTH-1:0] fwd_word_q, fwd_word_d;
  always_comb begin
    fwd_hit_d  = commit && (wr_addr_q == rd_addr_now);
    fwd_lane_d = wr_lane_q;
    fwd_word_d = pack(din_q, pin_q);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_hit_q  <= 1'b0;
      fwd_lane_q <= '0;
      fwd_word_q <= '0;
    end else begin
      fwd_hit_q  <= fwd_hit_d;
      fwd_lane_q <= fwd_lane_d;
      fwd_word_q <= fwd_word_d;
    end
  end

  // sleep entry and exit, two cycles each; the array is never cleared
  always_comb begin
    pwr_d     = pwr_q;
    slp_cnt_d = slp_cnt_q;
    case (pwr_q)
      PWR_AWAKE: begin
        if (zz_q) begin
          pwr_d     = PWR_ENTERING;
          slp_cnt_d = 2'(SLEEP_CYCLES - 1);
        end
      end
      PWR_ENTERING: begin
        if (slp_cnt_q == SLEEP_CNT_RESET) begin
          pwr_d = PWR_ASLEEP;
        end else begin
          slp_cnt_d = slp_cnt_q - STEP_ONE;
        end
      end
      PWR_ASLEEP: begin
        if (!zz_q) begin
          pwr_d     = PWR_LEAVING;
          slp_cnt_d = 2'(SLEEP_CYCLES - 1);
        end
      end
      PWR_LEAVING: begin
        if (slp_cnt_q == SLEEP_CNT_RESET) begin
          pwr_d = PWR_AWAKE;
        end else begin
          slp_cnt_d = slp_cnt_q - STEP_ONE;
        end
      end
      default: begin
        pwr_d     = PWR_AWAKE;
        slp_cnt_d = SLEEP_CNT_RESET;
      end
    endcase
    asleep_d = (pwr_d != PWR_AWAKE);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q     <= PWR_AWAKE;
      slp_cnt_q <= SLEEP_CNT_RESET;
      asleep    <= 1'b0;
    end else begin
      pwr_q     <= pwr_d;
      slp_cnt_q <= slp_cnt_d;
      asleep    <= asleep_d;
    end
  end

  // output drivers: registered data and enables; enable falls during writes
  logic [DW-1:0]    dout_d;
  logic [LANES-1:0] pout_d;
  logic             drive_d;
  logic [LANE_WIDTH-1:0] lane_word;
  always_comb begin
    lane_word = '0;
    for (int i = 0; i < LANES; i++) begin
      // freshly committed lanes win over the stale array word
      lane_word = (fwd_hit_q && fwd_lane_q[i]) ? fwd_word_q[i*LANE_WIDTH +: LANE_WIDTH]
                                               : rd_word[i*LANE_WIDTH +: LANE_WIDTH];
      dout_d[i*BYTE_WIDTH +: BYTE_WIDTH] = lane_word[BYTE_WIDTH-1:0];
      pout_d[i] = lane_word[BYTE_WIDTH];
    end
    // the enable is sampled, not truly asynchronous, so it lags by one edge
    drive_d = rd_valid_q && !wr_pend_q && !output_drive_enable_n && awake && !zz_q;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out                <= '0;
      data_oe                 <= '0;
      shared_parity_lines_out <= '0;
      shared_parity_lines_oe  <= '0;
    end else begin
      data_out                <= dout_d;
      data_oe                 <= {DW{drive_d}};
      shared_parity_lines_out <= pout_d;
      shared_parity_lines_oe  <= {LANES{drive_d}};
    end
  end

  // oe_n_q kept for symmetry of capture; read only to keep the enable path observable
  logic unused_oe;
  assign unused_oe = oe_n_q;
endmodule

// ---- src/sram_array.sv ----
// storage array with per-lane write and registered read data
`timescale 1ns/100ps
module sram_array
  import burst_sram_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_WIDTH_DEF,
  parameter int LANES      = LANES_DEF
) (
  // clock
  input  wire logic                          core_clk,
  // write side
  input  wire logic                          wr_en,
  input  wire logic [LANES-1:0]              wr_lane,
  input  wire logic [ADDR_WIDTH-1:0]         wr_addr,
  input  wire logic [LANES*LANE_WIDTH-1:0]   wr_data,
  // read side
  input  wire logic [ADDR_WIDTH-1:0]         rd_addr,
  output logic      [LANES*LANE_WIDTH-1:0]   rd_data_q
);
  logic [LANES*LANE_WIDTH-1:0] mem [0:(1<<ADDR_WIDTH)-1];

  // no reset on the array: contents survive sleep and are undefined at power-up
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (wr_en && wr_lane[i]) begin
        mem[wr_addr][i*LANE_WIDTH +: LANE_WIDTH] <= wr_data[i*LANE_WIDTH +: LANE_WIDTH];
      end
    end
    rd_data_q <= mem[rd_addr];
  end
endmodule
